// file: shared/isfcp_pkg.sv
// constants for the serial bus status flags and transfer clock prescaler
`default_nettype none
package isfcp_pkg;
  // ----------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_PRESCALER = 16'hffb2;
  localparam logic [15:0] IDX_STATUS = 16'hffb0;
  localparam logic [15:0] IDX_CONTROL = 16'hffb6;
  localparam logic [15:0] IDX_IRQ_STS = 16'hffba;
  localparam logic [15:0] IDX_IRQ_MSK = 16'hffbc;
  localparam logic [ADDR_W-1:0] ADDR_PRESCALER = {IDX_PRESCALER, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = {IDX_IRQ_STS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = {IDX_IRQ_MSK, 2'b00};
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_CLOCK_LINE_LEVEL = 5;
  localparam int B_DATA_LINE_LEVEL = 4;
  localparam int B_FAST_MODE_SELECT = 3;
  localparam int B_INPUT_FILTER_ENABLE = 2;
  localparam int B_RATE_SELECT_HIGH = 1;
  localparam int B_RATE_SELECT_LOW = 0;
  localparam int B_UNIT_ON = 7;
  localparam int B_COMM_RELEASE = 6;
  localparam int B_WAIT_RELEASE = 5;
  localparam int B_TRANSMIT_STATE = 3;
  localparam int B_ACK_SEEN = 2;
  localparam int B_START_SEEN = 1;
  localparam int B_STOP_SEEN = 0;
  localparam logic [3:0] PRS_RESET = 4'h0;
  localparam logic [3:0] NINTH_CLOCK = 4'h9;
  localparam logic [3:0] EIGHTH_CLOCK = 4'h8;
  localparam logic [3:0] FIRST_CLOCK = 4'h1;
  // ----------------------------------------------------------------
  // transfer clock divisors
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_STD_0 = 8'h2c;
  localparam logic [7:0] DIV_STD_1 = 8'h56;
  localparam logic [7:0] DIV_STD_2 = 8'hac;
  localparam logic [7:0] DIV_STD_AUX = 8'h42;
  localparam logic [7:0] DIV_FLT_0 = 8'h2e;
  localparam logic [7:0] DIV_FLT_1 = 8'h58;
  localparam logic [7:0] DIV_FLT_2 = 8'hb0;
  localparam logic [7:0] DIV_FLT_AUX = 8'h44;
  localparam logic [7:0] DIV_FAST_0 = 8'h18;
  localparam logic [7:0] DIV_FAST_1 = 8'h30;
  localparam logic [7:0] DIV_FAST_AUX = 8'h12;
endpackage
`default_nettype wire

// file: core/isfcp_core.sv
// serial bus status flags, transfer clock prescaler and apb register slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module isfcp_core #(
  parameter int FILT_LEN = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [isfcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialClockPinIn,
  input wire logic serialDataPinIn,
  output logic serialDataPinOut,
  output logic serialDataPinOe,
  input wire logic txDataBit,
  input wire logic auxTimerOut,
  output logic transferClk,
  output logic irq
);
  import isfcp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] prs;
    logic unitOn;
    logic [2:0] irqSts;
    logic [2:0] irqMsk;
    logic startSeen;
    logic stopSeen;
    logic ackSeen;
    logic txState;
    logic firstByte;
    logic [3:0] bitCnt;
    logic sclF;
    logic sdaF;
    logic sclP;
    logic sdaP;
    logic [3:0] fCntScl;
    logic [3:0] fCntSda;
    logic clkLvl;
    logic datLvl;
    logic auxPrev;
    logic [7:0] divCnt;
    logic xferClk;
    logic sdaOe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } isfcp_state_t;

  isfcp_state_t s_q;
  isfcp_state_t s_d;
  logic access;
  logic finish;
  logic sclRise;
  logic startDet;
  logic stopDet;
  logic relPulse;
  logic waitRelPulse;
  logic [7:0] divisor;

  // ----------------------------------------------------------------
  // combinational events
  // ----------------------------------------------------------------
  // edges use the filtered copies, one cycle late, so glitches do not count while the input filter is enabled
  assign access = psel & penable;
  assign finish = access & s_q.pready;
  assign sclRise = s_q.unitOn & s_q.sclF & ~s_q.sclP;
  assign startDet = s_q.unitOn & s_q.sclF & s_q.sclP & s_q.sdaP & ~s_q.sdaF;
  assign stopDet = s_q.unitOn & s_q.sclF & s_q.sclP & ~s_q.sdaP & s_q.sdaF;
  assign relPulse = finish & pwrite & (paddr == ADDR_CONTROL) & pstrb[0] & pwdata[B_COMM_RELEASE];
  assign waitRelPulse = finish & pwrite & (paddr == ADDR_CONTROL) & pstrb[0]
    & pwdata[B_WAIT_RELEASE];

  // byte strobe writes the byte; otherwise lane 1 is a mask of single bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] st);
    logic [7:0] r;
    r = old;
    if (st[0]) begin
      r = wd[7:0];
    end else if (st[1]) begin
      r = (old & ~wd[15:8]) | (wd[7:0] & wd[15:8]);
    end
    return r;
  endfunction

  // divisor choice from mode, filter and rate select
  always_comb begin
    logic [1:0] rate;
    rate = s_q.prs[B_RATE_SELECT_HIGH:B_RATE_SELECT_LOW];
    if (s_q.prs[B_FAST_MODE_SELECT]) begin
      // filter bit plays no part in fast mode
      case (rate)
        2'b10: divisor = DIV_FAST_1;
        2'b11: divisor = DIV_FAST_AUX;
        default: divisor = DIV_FAST_0;
      endcase
    end else if (s_q.prs[B_INPUT_FILTER_ENABLE]) begin
      case (rate)
        2'b00: divisor = DIV_FLT_0;
        2'b01: divisor = DIV_FLT_1;
        2'b10: divisor = DIV_FLT_2;
        default: divisor = DIV_FLT_AUX;
      endcase
    end else begin
      case (rate)
        2'b00: divisor = DIV_STD_0;
        2'b01: divisor = DIV_STD_1;
        2'b10: divisor = DIV_STD_2;
        default: divisor = DIV_STD_AUX;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] w;
    logic [2:0] ev;
    logic tick;
    w = 8'h00;
    ev = 3'b000;
    tick = 1'b0;
    s_d = s_q;
    // input filter: a change is taken only after FILT_LEN steady samples
    s_d.sclP = s_q.sclF;
    s_d.sdaP = s_q.sdaF;
    if (!s_q.prs[B_INPUT_FILTER_ENABLE] || serialClockPinIn == s_q.sclF) begin
      s_d.sclF = serialClockPinIn;
      s_d.fCntScl = 4'h0;
    end else if (s_q.fCntScl == 4'(FILT_LEN - 1)) begin
      s_d.sclF = serialClockPinIn;
      s_d.fCntScl = 4'h0;
    end else begin
      s_d.fCntScl = s_q.fCntScl + 4'h1;
    end
    if (!s_q.prs[B_INPUT_FILTER_ENABLE] || serialDataPinIn == s_q.sdaF) begin
      s_d.sdaF = serialDataPinIn;
      s_d.fCntSda = 4'h0;
    end else if (s_q.fCntSda == 4'(FILT_LEN - 1)) begin
      s_d.sdaF = serialDataPinIn;
      s_d.fCntSda = 4'h0;
    end else begin
      s_d.fCntSda = s_q.fCntSda + 4'h1;
    end
    // line levels as software sees them
    s_d.clkLvl = s_q.unitOn & s_q.sclF;
    s_d.datLvl = s_q.unitOn & s_q.sdaF;
    // release clears come before the line events so a same-cycle set wins
    if (relPulse) begin
      s_d.ackSeen = 1'b0;
      s_d.startSeen = 1'b0;
      s_d.txState = 1'b0;
    end
    // bit counter and clears: clears first so a same-cycle set wins
    if (sclRise) begin
      if (s_q.bitCnt == NINTH_CLOCK || s_q.bitCnt == 4'h0) begin
        s_d.bitCnt = FIRST_CLOCK;
        s_d.ackSeen = 1'b0;
        // a ninth count here means this rise opens the byte after the last one
        if (s_q.bitCnt == NINTH_CLOCK) begin
          s_d.startSeen = 1'b0;
          s_d.firstByte = 1'b0;
        end else if (s_q.firstByte && s_q.startSeen) begin
          s_d.stopSeen = 1'b0;
        end
      end else begin
        s_d.bitCnt = s_q.bitCnt + 4'h1;
      end
      // direction bit of the first byte puts a slave into transmit
      if (s_q.firstByte && s_q.bitCnt == 4'h7 && s_q.sdaF) begin
        s_d.txState = 1'b1;
      end
      if (s_q.bitCnt == EIGHTH_CLOCK && !s_q.sdaF) begin
        s_d.ackSeen = 1'b1;
        ev[B_ACK_SEEN] = 1'b1;
      end
    end
    if (stopDet) begin
      s_d.ackSeen = 1'b0;
      s_d.startSeen = 1'b0;
      s_d.txState = 1'b0;
      s_d.bitCnt = 4'h0;
      s_d.stopSeen = 1'b1;
      ev[B_STOP_SEEN] = 1'b1;
    end
    if (startDet) begin
      s_d.startSeen = 1'b1;
      s_d.firstByte = 1'b1;
      s_d.txState = 1'b0;
      s_d.bitCnt = 4'h0;
      ev[B_START_SEEN] = 1'b1;
    end
    // releasing the ninth-clock wait as transmitter hands the line back
    if (waitRelPulse && s_q.txState && s_q.bitCnt == NINTH_CLOCK) begin
      s_d.txState = 1'b0;
    end
    // open drain: only ever pull low; a new data bit is put out only while the
    // clock line is low, but leaving transmit lets the line go at once, whatever the clock level
    if (!s_d.txState) begin
      s_d.sdaOe = 1'b0;
    end else if (!s_q.sclF) begin
      s_d.sdaOe = ~txDataBit;
    end
    // transfer clock: square wave, toggling every half divisor of ticks
    tick = (s_q.prs[B_RATE_SELECT_HIGH:B_RATE_SELECT_LOW] == 2'b11)
      ? (auxTimerOut & ~s_q.auxPrev) : 1'b1;
    s_d.auxPrev = auxTimerOut;
    if (s_q.unitOn && tick) begin
      if (s_q.divCnt >= (divisor >> 1) - 8'h01) begin
        s_d.divCnt = 8'h00;
        s_d.xferClk = ~s_q.xferClk;
      end else begin
        s_d.divCnt = s_q.divCnt + 8'h01;
      end
    end
    // apb: one wait state, answer on the second access cycle
    s_d.pready = access & ~s_q.pready;
    if (access && !s_q.pready) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        ADDR_PRESCALER: begin
          // bits 7 and 6 stay zero, level bits come from the line
          s_d.prdata[7:0] = {2'b00, s_q.clkLvl, s_q.datLvl, s_q.prs};
        end
        ADDR_STATUS: begin
          s_d.prdata[B_TRANSMIT_STATE] = s_q.txState;
          s_d.prdata[B_ACK_SEEN] = s_q.ackSeen;
          s_d.prdata[B_START_SEEN] = s_q.startSeen;
          s_d.prdata[B_STOP_SEEN] = s_q.stopSeen;
        end
        ADDR_CONTROL: s_d.prdata[B_UNIT_ON] = s_q.unitOn;
        ADDR_IRQ_STS: s_d.prdata[2:0] = s_q.irqSts;
        ADDR_IRQ_MSK: s_d.prdata[2:0] = s_q.irqMsk;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (finish) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = s_q.prdata;
    end
    s_d.irqSts = s_q.irqSts;
    if (finish && !pwrite && paddr == ADDR_IRQ_STS) begin
      s_d.irqSts = 3'b000;
    end
    if (finish && pwrite) begin
      case (paddr)
        ADDR_PRESCALER: begin
          // level bits are not stored, so writes cannot touch them
          w = merge({4'h0, s_q.prs}, pwdata, pstrb);
          s_d.prs = w[3:0];
        end
        ADDR_CONTROL: begin
          w = merge({s_q.unitOn, 7'h00}, pwdata, pstrb);
          s_d.unitOn = w[B_UNIT_ON];
        end
        ADDR_IRQ_MSK: begin
          w = merge({5'h00, s_q.irqMsk}, pwdata, pstrb);
          s_d.irqMsk = w[2:0];
        end
        default: w = 8'h00;
      endcase
    end
    // events set after the read clear so none is lost
    s_d.irqSts = s_d.irqSts | ev;
    // a disabled unit holds every status flag and line reading at zero; interrupt status keeps its bits
    if (!s_q.unitOn) begin
      s_d.ackSeen = 1'b0;
      s_d.startSeen = 1'b0;
      s_d.stopSeen = 1'b0;
      s_d.txState = 1'b0;
      s_d.firstByte = 1'b0;
      s_d.bitCnt = 4'h0;
      s_d.sdaOe = 1'b0;
      s_d.divCnt = 8'h00;
      s_d.xferClk = 1'b0;
    end
    s_d.irq = |(s_d.irqSts & s_d.irqMsk);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset; lines start idle high so reset makes no false start
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.prs <= PRS_RESET;
      s_q.sclF <= 1'b1;
      s_q.sdaF <= 1'b1;
      s_q.sclP <= 1'b1;
      s_q.sdaP <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign serialDataPinOut = 1'b0;
  assign serialDataPinOe = s_q.sdaOe;
  assign transferClk = s_q.xferClk;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ack_set: assert property (@(posedge mclk) disable iff (!rst_b)
    sclRise && s_q.bitCnt == NINTH_CLOCK - 4'h1 && !s_q.sdaF |=> s_q.ackSeen)
    else $error("ack flag not set at ninth clock");
  chk_ack_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    stopDet || !s_q.unitOn |=> !s_q.ackSeen)
    else $error("ack flag survived stop or disable");
  chk_tx_release: assert property (@(posedge mclk) disable iff (!rst_b)
    waitRelPulse && s_q.txState && s_q.bitCnt == NINTH_CLOCK |=> !s_q.txState ##1 !s_q.sdaOe)
    else $error("wait release left data line driven");
  chk_start_set: assert property (@(posedge mclk) disable iff (!rst_b)
    startDet |=> s_q.startSeen && s_q.bitCnt == 4'h0)
    else $error("start flag not set");
  chk_start_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    stopDet |=> !s_q.startSeen)
    else $error("start flag survived stop");
  chk_stop_set: assert property (@(posedge mclk) disable iff (!rst_b)
    stopDet |=> s_q.stopSeen)
    else $error("stop flag not set");
  chk_stop_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.stopSeen && s_q.unitOn && !sclRise |=> s_q.stopSeen)
    else $error("stop flag dropped early");
  chk_prs_reset: assert property (@(posedge mclk)
    !rst_b |=> s_q.prs == PRS_RESET && !s_q.clkLvl)
    else $error("prescaler not zero after reset");
  chk_level_off: assert property (@(posedge mclk) disable iff (!rst_b)
    !s_q.unitOn ##1 !s_q.unitOn |-> !s_q.clkLvl && !s_q.datLvl)
    else $error("line level bits set while disabled");
  chk_fast_div: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.prs[B_FAST_MODE_SELECT] && s_q.prs[1:0] == 2'b00 |-> divisor == DIV_FAST_0)
    else $error("fast mode divisor wrong");
  chk_ack_byte_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    sclRise && s_q.bitCnt == NINTH_CLOCK |=> !s_q.ackSeen)
    else $error("ack flag kept into next byte");
  chk_start_byte_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    sclRise && s_q.bitCnt == NINTH_CLOCK |=> !s_q.startSeen)
    else $error("start flag kept past address byte");
  chk_stop_addr_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    sclRise && s_q.bitCnt == 4'h0 && s_q.firstByte && s_q.startSeen |=> !s_q.stopSeen)
    else $error("stop flag kept into address byte");
  chk_level_on: assert property (@(posedge mclk) disable iff (!rst_b)
    s_q.unitOn |=> s_q.clkLvl == $past(s_q.sclF) && s_q.datLvl == $past(s_q.sdaF))
    else $error("line level bits do not follow the lines");
  chk_prs_upper: assert property (@(posedge mclk) disable iff (!rst_b)
    finish && !pwrite && paddr == ADDR_PRESCALER |-> s_q.prdata[31:6] == 26'h000_0000)
    else $error("prescaler upper bits read nonzero");
  chk_std_div: assert property (@(posedge mclk) disable iff (!rst_b)
    !s_q.prs[B_FAST_MODE_SELECT] && !s_q.prs[B_INPUT_FILTER_ENABLE]
      && s_q.prs[B_RATE_SELECT_HIGH:B_RATE_SELECT_LOW] == 2'b01 |-> divisor == DIV_STD_1)
    else $error("standard mode divisor wrong");
  chk_filter_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    FILT_LEN > 1 && s_q.prs[B_INPUT_FILTER_ENABLE] && s_q.fCntScl == 4'h0
      && serialClockPinIn != s_q.sclF |=> s_q.sclF == $past(s_q.sclF))
    else $error("filter passed a one-sample change");
  chk_bit_write: assert property (@(posedge mclk) disable iff (!rst_b)
    finish && pwrite && paddr == ADDR_PRESCALER && !pstrb[0] && pstrb[1]
      && !pwdata[8 + B_INPUT_FILTER_ENABLE]
      |=> s_q.prs[B_INPUT_FILTER_ENABLE] == $past(s_q.prs[B_INPUT_FILTER_ENABLE]))
    else $error("single-bit write changed an unmasked bit");
endmodule
`default_nettype wire

// file: verification/isfcp_bus_peer.sv
// model of another master on the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module isfcp_bus_peer #(
  parameter int HOLD = 10
) (
  input wire logic mclk,
  output logic sclLine,
  output logic sdaDrv
);
  // ----------------------------------------------------------------
  // line phases
  // ----------------------------------------------------------------
  // both lines idle high through the pull-ups
  initial begin
    sclLine = 1'b1;
    sdaDrv = 1'b1;
  end
  // one phase; called right after an edge, held long enough for the filter
  task automatic step(input logic c, input logic d);
    sclLine <= c;
    sdaDrv <= d;
    repeat (HOLD) @(posedge mclk);
  endtask
  // data falls while clock is high
  task automatic start();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // data only moves while the clock is low, so no false start or stop
  task automatic bitOut(input logic b);
    step(1'b0, sdaDrv);
    step(1'b0, b);
    step(1'b1, b);
  endtask
  // data rises while clock is high
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// file: verification/isfcp_core_bench.sv
// self-checking bench for the status flags and transfer clock prescaler
`timescale 1ns/1ps
`default_nettype none
module isfcp_core_bench;
  import isfcp_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic txDataBit = 1'b0;
  logic auxTimerOut = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sdaOut, sdaOe, transferClk, irq, sclLine, sdaDrv, err;
  logic [31:0] rd;
  wire logic sdaWire;
  int nMismatch = 0;
  int nChecks = 0;
  int cycles = 0;
  int modeTab[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
  int perTab[15] = '{44, 86, 172, 132, 46, 88, 176, 136, 24, 24, 48, 36, 24, 48, 36};
  // ----------------------------------------------------------------
  // clock, aux ticks, open-drain data wire, timeout
  // ----------------------------------------------------------------
  always #50 mclk = ~mclk;
  // aux rises every second cycle, so aux periods count twice in mclk
  always @(posedge mclk) begin
    auxTimerOut <= ~auxTimerOut;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nMismatch++;
      complete_run();
    end
  end
  // wired-and of both parties with the pull-up
  assign sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);
  isfcp_core #(.FILT_LEN(2)) isfcp_core_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialClockPinIn(sclLine),
    .serialDataPinIn(sdaWire), .serialDataPinOut(sdaOut), .serialDataPinOe(sdaOe),
    .txDataBit(txDataBit), .auxTimerOut(auxTimerOut), .transferClk(transferClk), .irq(irq));
  isfcp_bus_peer #(.HOLD(10)) isfcp_bus_peer_inst (.mclk(mclk), .sclLine(sclLine),
    .sdaDrv(sdaDrv));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends a stuck wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following setup never reassigns psel in this step
    @(posedge mclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, exp);
  endtask
  task automatic waitLvl(input logic v, inout int n);
    while (transferClk !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdChk(ADDR_PRESCALER, 32'h0000_0000);
    rdChk(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_PRESCALER, 32'h0000_00ff);
    rdChk(ADDR_PRESCALER, 32'h0000_000f);
    // single-bit write: mask bits 5..3, data zero; level bits must not move
    apb(1'b1, ADDR_PRESCALER, 32'h0000_3800, 4'h2);
    rdChk(ADDR_PRESCALER, 32'h0000_0007);
    apb(1'b0, 18'h0_0010, 32'h0000_0000, 4'h0);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test access done");
    wr(ADDR_IRQ_MSK, 32'h0000_0007);
    wr(ADDR_CONTROL, 32'h0000_0080);
    wr(ADDR_PRESCALER, 32'h0000_0004);
    rdChk(ADDR_PRESCALER, 32'h0000_0034);
    isfcp_bus_peer_inst.step(1'b0, 1'b1);
    rdChk(ADDR_PRESCALER, 32'h0000_0014);
    isfcp_bus_peer_inst.step(1'b0, 1'b0);
    rdChk(ADDR_PRESCALER, 32'h0000_0004);
    isfcp_bus_peer_inst.step(1'b0, 1'b1);
    $display("test levels done");
    // sync on one rising edge, then time a whole period
    for (int i = 0; i < 15; i++) begin
      wr(ADDR_PRESCALER, 32'(modeTab[i]));
      n = 0;
      waitLvl(1'b0, n);
      waitLvl(1'b1, n);
      n = 0;
      waitLvl(1'b0, n);
      waitLvl(1'b1, n);
      chk(32'(n), 32'(perTab[i]));
    end
    wr(ADDR_PRESCALER, 32'h0000_0004);
    $display("test divisors done");
    isfcp_bus_peer_inst.start();
    chk({31'h0, irq}, 32'h0000_0001);
    rdChk(ADDR_STATUS, 32'h0000_0002);
    rdChk(ADDR_IRQ_STS, 32'h0000_0002);
    rdChk(ADDR_IRQ_STS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ADDR_IRQ_MSK, 32'h0000_0000);
    // address byte with read direction, acknowledged low at ninth clock
    for (int i = 8; i >= 0; i--) begin
      isfcp_bus_peer_inst.bitOut(9'h156 >> i);
    end
    rdChk(ADDR_STATUS, 32'h0000_000e);
    chk({31'h0, sdaOe}, 32'h0000_0001);
    chk({31'h0, sdaOut}, 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_00a0);
    chk({31'h0, sdaOe}, 32'h0000_0000);
    rdChk(ADDR_STATUS, 32'h0000_0006);
    isfcp_bus_peer_inst.bitOut(1'b1);
    rdChk(ADDR_STATUS, 32'h0000_0000);
    isfcp_bus_peer_inst.stop();
    rdChk(ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    rdChk(ADDR_IRQ_STS, 32'h0000_0005);
    $display("test frame done");
    isfcp_bus_peer_inst.start();
    rdChk(ADDR_STATUS, 32'h0000_0003);
    isfcp_bus_peer_inst.bitOut(1'b1);
    rdChk(ADDR_STATUS, 32'h0000_0002);
    wr(ADDR_CONTROL, 32'h0000_00c0);
    rdChk(ADDR_STATUS, 32'h0000_0000);
    isfcp_bus_peer_inst.start();
    rdChk(ADDR_STATUS, 32'h0000_0002);
    wr(ADDR_CONTROL, 32'h0000_0000);
    rdChk(ADDR_STATUS, 32'h0000_0000);
    rdChk(ADDR_PRESCALER, 32'h0000_0004);
    $display("test clear done");
    complete_run();
  end
endmodule
`default_nettype wire
